// ==== hdl/encoder_pulse_trigger_gen.sv ====
// Purpose: Measurement trigger generator from an incremental A/B/Z encoder
// Assumes: Encoder, window and step inputs already synchronous to mclk
// Notes:   APB slave with zero wait states; status shows live counters
`timescale 1ns/100ps
`default_nettype none
`include "enc_trig_defines.svh"

module encoder_pulse_trigger_gen
(
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire enc_trig_pkg::enc_in_t enc_in,
    output logic                   trig_pulse
);
    import enc_trig_pkg::*;

    state_t s_q;
    state_t s_d;

    logic        setup;
    logic        access;
    logic        mapped;
    logic        a_rise;
    logic        z_rise;
    logic        step_rise;
    logic        dir_rev;
    logic        a_fwd;
    logic        src_pulse;
    logic        count_ok;
    logic        rot_event;
    logic        hit;
    logic [15:0] cnt_inc;
    logic [15:0] rcnt_inc;

    always_comb
    begin
        setup     = psel && !penable;
        access    = psel && penable;
        mapped    = (paddr == `OFS_CTRL) || (paddr == `OFS_RESOLUTION) || (paddr == `OFS_A_TARGET)
                    || (paddr == `OFS_Z_TARGET) || (paddr == `OFS_STATUS);
        a_rise    = enc_in.a && !s_q.prev.a;
        z_rise    = enc_in.z && !s_q.prev.z;
        step_rise = enc_in.step && !s_q.prev.step;
        dir_rev   = s_q.ctrl.backlash && enc_in.b;
        a_fwd     = a_rise && (!dir_rev || s_q.ctrl.rev_trig);
        src_pulse = s_q.ctrl.src_z ? z_rise : a_fwd;
        count_ok  = s_q.ctrl.en && enc_in.window && (!s_q.ctrl.step_start || s_q.armed);
        cnt_inc   = s_q.cnt + 16'h0001;
        rcnt_inc  = s_q.rcnt + 16'h0001;
        rot_event = s_q.ctrl.rot_by_z ? z_rise : (a_rise && !dir_rev && rcnt_inc >= s_q.resolution);
        if (s_q.ctrl.src_z)
        begin
            hit = cnt_inc >= {6'h00, s_q.z_target};
        end
        else if (s_q.ctrl.per_rot)
        begin
            hit = cnt_inc == s_q.a_target;
        end
        else
        begin
            hit = cnt_inc >= s_q.a_target;
        end
    end

    always_comb
    begin
        s_d      = s_q;
        s_d.prev = enc_in;
        s_d.trig = 1'b0;

        if (setup)
        begin
            unique case (paddr)
                `OFS_CTRL:       s_d.rdata = {25'h0000000, s_q.ctrl};
                `OFS_RESOLUTION: s_d.rdata = {16'h0000, s_q.resolution};
                `OFS_A_TARGET:   s_d.rdata = {16'h0000, s_q.a_target};
                `OFS_Z_TARGET:   s_d.rdata = {22'h000000, s_q.z_target};
                `OFS_STATUS:     s_d.rdata = {s_q.rots, 6'h00, s_q.armed, s_q.rev, s_q.cnt};
                default:         s_d.rdata = 32'h00000000;
            endcase
        end

        // Rotation logic ignores window and step gating so the index stays in phase; rcnt clears while disabled, rots holds
        if (!s_q.ctrl.en)
        begin
            s_d.rcnt = 16'h0000;
        end
        else if (rot_event)
        begin
            s_d.rcnt = 16'h0000;
            s_d.rots = s_q.rots + 8'h01;
        end
        else if (a_rise && !dir_rev)
        begin
            s_d.rcnt = rcnt_inc;
        end

        // Arming only lives inside one receipt window
        if (!enc_in.window || !s_q.ctrl.en)
        begin
            s_d.armed = 1'b0;
        end
        else if (step_rise)
        begin
            s_d.armed = 1'b1;
        end

        // Direction latch
        // Held between pulses so status still shows it while the shaft rests
        if (!s_q.ctrl.backlash)
        begin
            s_d.rev = 1'b0;
        end
        else if (a_rise)
        begin
            s_d.rev = dir_rev;
        end

        if (!count_ok)
        begin
            s_d.cnt = 16'h0000;
        end
        else
        begin
            // Per-rotation clear
            // The pulse that closes a rotation by count is not itself counted
            if (!s_q.ctrl.src_z && s_q.ctrl.per_rot && rot_event)
            begin
                s_d.cnt = 16'h0000;
            end
            else if (src_pulse)
            begin
                if (hit)
                begin
                    s_d.trig = 1'b1;
                    s_d.cnt  = (s_q.ctrl.per_rot && !s_q.ctrl.src_z) ? cnt_inc : 16'h0000;
                end
                else
                begin
                    s_d.cnt = cnt_inc;
                end
            end
        end

        if (access && pwrite)
        begin
            unique case (paddr)
                `OFS_CTRL:       s_d.ctrl = ctrl_t'(pwdata[`CTRL_WIDTH-1:0]);
                `OFS_RESOLUTION: s_d.resolution = (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
                `OFS_A_TARGET:   s_d.a_target = pwdata[15:0];
                `OFS_Z_TARGET:   s_d.z_target = (pwdata[9:0] == 10'h000) ? 10'h001 : pwdata[9:0];
                default:         s_d.ctrl = s_q.ctrl;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            s_q            <= '0;
            s_q.ctrl       <= ctrl_t'(`RST_CTRL);
            s_q.resolution <= `RST_RESOLUTION;
            s_q.a_target   <= `RST_A_TARGET;
            s_q.z_target   <= `RST_Z_TARGET;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign prdata     = s_q.rdata;
    assign pready     = 1'b1;
    assign pslverr    = access && !mapped;
    assign trig_pulse = s_q.trig;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    property p_enable_gate;
        !s_q.ctrl.en |=> !trig_pulse;
    endproperty
    a_enable_gate: assert property (p_enable_gate) else $error("trigger while disabled");

    property p_res_nonzero;
        s_q.resolution != 16'h0000;
    endproperty
    a_res_nonzero: assert property (p_res_nonzero) else $error("resolution is zero");

    property p_res_zero_write;
        (access && pwrite && (paddr == `OFS_RESOLUTION) && (pwdata[15:0] == 16'h0000))
            |=> (s_q.resolution == 16'h0001);
    endproperty
    a_res_zero_write: assert property (p_res_zero_write) else $error("zero resolution not stored as one");

    property p_rot_a;
        (s_q.ctrl.en && !s_q.ctrl.rot_by_z && a_rise && !dir_rev && rcnt_inc >= s_q.resolution)
            |=> (s_q.rcnt == 16'h0000) && (s_q.rots == $past(s_q.rots) + 8'h01);
    endproperty
    a_rot_a: assert property (p_rot_a) else $error("rotation by count missed");

    property p_rot_z;
        (s_q.ctrl.en && s_q.ctrl.rot_by_z && z_rise)
            |=> (s_q.rcnt == 16'h0000) && (s_q.rots == $past(s_q.rots) + 8'h01);
    endproperty
    a_rot_z: assert property (p_rot_z) else $error("rotation by index missed");

    property p_source;
        trig_pulse |-> ($past(s_q.ctrl.src_z) ? $past(z_rise) : $past(a_rise));
    endproperty
    a_source: assert property (p_source) else $error("trigger from wrong phase");

    property p_window;
        trig_pulse |-> $past(enc_in.window);
    endproperty
    a_window: assert property (p_window) else $error("trigger outside window");

    property p_gate_zero;
        !count_ok |=> (s_q.cnt == 16'h0000);
    endproperty
    a_gate_zero: assert property (p_gate_zero) else $error("count kept while gated");

    property p_step;
        (trig_pulse && $past(s_q.ctrl.step_start)) |-> $past(s_q.armed);
    endproperty
    a_step: assert property (p_step) else $error("trigger before step");

    property p_a_clear;
        (trig_pulse && !$past(s_q.ctrl.src_z) && !$past(s_q.ctrl.per_rot)) |-> s_q.cnt == 16'h0000;
    endproperty
    a_a_clear: assert property (p_a_clear) else $error("A count not cleared");

    property p_per_rot;
        (count_ok && !s_q.ctrl.src_z && s_q.ctrl.per_rot && rot_event)
            |=> (s_q.cnt == 16'h0000) && !trig_pulse;
    endproperty
    a_per_rot: assert property (p_per_rot) else $error("count not cleared at rotation");

    property p_z_clear;
        (trig_pulse && $past(s_q.ctrl.src_z)) |-> s_q.cnt == 16'h0000;
    endproperty
    a_z_clear: assert property (p_z_clear) else $error("Z count not cleared");

    property p_z_hit;
        (count_ok && s_q.ctrl.src_z && z_rise && (cnt_inc >= {6'h00, s_q.z_target}))
            |=> trig_pulse && (s_q.cnt == 16'h0000);
    endproperty
    a_z_hit: assert property (p_z_hit) else $error("Z target reached without trigger");

    property p_z_target;
        (trig_pulse && $past(s_q.ctrl.src_z)) |-> ($past(s_q.cnt) + 16'h0001 >= {6'h00, $past(s_q.z_target)});
    endproperty
    a_z_target: assert property (p_z_target) else $error("Z trigger before target");

    property p_a_hit;
        (count_ok && !s_q.ctrl.src_z && !s_q.ctrl.per_rot && a_fwd && (cnt_inc >= s_q.a_target))
            |=> trig_pulse;
    endproperty
    a_a_hit: assert property (p_a_hit) else $error("A target reached without trigger");

    property p_dir;
        !s_q.ctrl.backlash |=> !s_q.rev;
    endproperty
    a_dir: assert property (p_dir) else $error("direction without backlash");

    property p_rev_latch;
        (s_q.ctrl.backlash && a_rise) |=> (s_q.rev == $past(enc_in.b));
    endproperty
    a_rev_latch: assert property (p_rev_latch) else $error("direction not taken at A edge");

    property p_reverse;
        (a_rise && dir_rev && !s_q.ctrl.rev_trig && !s_q.ctrl.src_z) |=> !trig_pulse;
    endproperty
    a_reverse: assert property (p_reverse) else $error("reverse trigger not blocked");

    property p_single;
        trig_pulse |=> !trig_pulse;
    endproperty
    a_single: assert property (p_single) else $error("trigger longer than one cycle");

    c_trig_a: cover property (trig_pulse && !s_q.ctrl.src_z);
    c_trig_z: cover property (trig_pulse && s_q.ctrl.src_z);
    c_step:   cover property (trig_pulse && s_q.ctrl.step_start);
    c_rot:    cover property (rot_event && s_q.ctrl.per_rot);
    c_rev:    cover property (a_rise && dir_rev && s_q.ctrl.rev_trig);

endmodule
`default_nettype wire

// ==== inc/enc_trig_defines.svh ====
// Purpose: Offsets, field positions, reset values for the encoder trigger block
// Assumes: APB slave, 32-bit data, one word per register
// Notes:   Operation list below
//
// Operation
// - Triggers only while the encoder trigger enable bit is set; off after reset.
// - Resolution register holds pulses per rotation, 1 to 65535, reset value 1.
// - Rotation from index pulse when selected, else when A count reaches resolution.
// - Trigger source is phase A or phase Z; phase A after reset.
// - Window start: count source pulses only while the receipt window is active.
// - Step start: ignore pulses in the window until step input is seen.
// - Phase A: clear count after each trigger, or once per rotation.
// - Phase Z: count always clears after each trigger.
// - Trigger when count reached; A target 0..65535 reset 0, Z 1..1023 reset 1.
// - Backlash option uses phase B with A for direction; off after reset.
// - Reverse rotation triggers only when trigger-in-reverse is set; off after reset. Code blocks only phase A reverse pulses, and only with backlash on.
`ifndef ENC_TRIG_DEFINES_SVH
`define ENC_TRIG_DEFINES_SVH

`define OFS_CTRL        8'h00
`define OFS_RESOLUTION  8'h04
`define OFS_A_TARGET    8'h08
`define OFS_Z_TARGET    8'h0c
`define OFS_STATUS      8'h10

`define CTRL_EN_BIT      0
`define CTRL_ROT_Z_BIT   1
`define CTRL_SRC_Z_BIT   2
`define CTRL_STEP_BIT    3
`define CTRL_PER_ROT_BIT 4
`define CTRL_BACKLASH_BIT 5
`define CTRL_REVTRIG_BIT 6
`define CTRL_WIDTH       7

`define RST_CTRL        7'h00
`define RST_RESOLUTION  16'h0001
`define RST_A_TARGET    16'h0000
`define RST_Z_TARGET    10'h001

`define STAT_DIR_BIT    16
`define STAT_ARMED_BIT  17
`define STAT_ROT_LSB    24

`endif

// ==== inc/enc_trig_pkg.sv ====
// Purpose: Types for the encoder trigger block
// Assumes: Constants live in enc_trig_defines.svh
// Notes:   Field order of ctrl_t matches the CTRL bit positions
package enc_trig_pkg;

    typedef struct packed {
        logic rev_trig;
        logic backlash;
        logic per_rot;
        logic step_start;
        logic src_z;
        logic rot_by_z;
        logic en;
    } ctrl_t;

    typedef struct packed {
        logic a;
        logic b;
        logic z;
        logic window;
        logic step;
    } enc_in_t;

    typedef struct packed {
        ctrl_t       ctrl;
        logic [15:0] resolution;
        logic [15:0] a_target;
        logic [9:0]  z_target;
        logic [31:0] rdata;
        enc_in_t     prev;
        logic        armed;
        logic        rev;
        logic [15:0] cnt;
        logic [15:0] rcnt;
        logic [7:0]  rots;
        logic        trig;
    } state_t;

endpackage

// ==== tb/enc_model.sv ====
// Purpose: Behavioural incremental encoder with index pulse
// Assumes: One A pulse per request, phases change just after mclk edges
// Notes:   Index comes after A falls on the last pulse of a turn
`timescale 1ns/100ps
`default_nettype none
module enc_model
#(
    parameter int PPR = 4
)
(
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic req,
    input  wire logic rev,
    output logic      a,
    output logic      b,
    output logic      z
);
    logic [2:0]  ph_q;
    logic        rev_q;
    logic [15:0] pos_q;
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            ph_q  <= 3'h0;
            rev_q <= 1'b0;
            pos_q <= 16'h0;
        end
        else if (ph_q == 3'h0)
        begin
            ph_q  <= req ? 3'h1 : 3'h0;
            rev_q <= rev;
        end
        else
        begin
            ph_q <= (ph_q == 3'h5) ? 3'h0 : ph_q + 3'h1;
            if (ph_q == 3'h5 && !rev_q)
                pos_q <= (pos_q == 16'(PPR - 1)) ? 16'h0 : pos_q + 16'h1;
        end
    end
    // Reverse: B already high as A rises; forward: B lags A
    assign a = (ph_q == 3'h1) || (ph_q == 3'h2);
    assign b = rev_q ? (ph_q != 3'h0 && ph_q < 3'h4) : (ph_q == 3'h2 || ph_q == 3'h3);
    // Kept apart from A edges so the clear order is never ambiguous
    assign z = !rev_q && (ph_q == 3'h4) && (pos_q == 16'(PPR - 1));
endmodule
`default_nettype wire

// ==== tb/encoder_pulse_trigger_gen_tb_top.sv ====
// Purpose: Self-checking bench for the encoder trigger generator
// Assumes: Zero wait APB slave, encoder model with four pulses a turn
// Notes:   Forward pulse bursts are multiples of four to keep the index aligned
`timescale 1ns/100ps
`default_nettype none
`include "enc_trig_defines.svh"
module encoder_pulse_trigger_gen_tb_top;
    import enc_trig_pkg::*;
    localparam logic [31:0] C_EN = 32'h1 << `CTRL_EN_BIT;
    localparam logic [31:0] C_ROTZ = 32'h1 << `CTRL_ROT_Z_BIT;
    localparam logic [31:0] C_SRCZ = 32'h1 << `CTRL_SRC_Z_BIT;
    localparam logic [31:0] C_STEP = 32'h1 << `CTRL_STEP_BIT;
    localparam logic [31:0] C_PROT = 32'h1 << `CTRL_PER_ROT_BIT;
    localparam logic [31:0] C_BACK = 32'h1 << `CTRL_BACKLASH_BIT;
    localparam logic [31:0] C_REV = 32'h1 << `CTRL_REVTRIG_BIT;
    logic        mclk = 1'b0;
    logic        rst, psel, penable, pwrite, pready, pslverr, trig_pulse;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdv, s0, trig_n;
    logic        req, rv, ea, eb, ez, win, stp, last_t, err;
    enc_in_t     enc_in;
    int          bad_count, n_checks;
    assign enc_in = '{a: ea, b: eb, z: ez, window: win, step: stp};
    always #4 mclk = ~mclk;
    encoder_pulse_trigger_gen encoder_pulse_trigger_gen_inst (.mclk(mclk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .enc_in(enc_in), .trig_pulse(trig_pulse));
    enc_model enc_model_inst (.mclk(mclk), .rst(rst), .req(req), .rev(rv), .a(ea), .b(eb), .z(ez));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            bad_count++;
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
        apb(1'b1, ad, wd);
    endtask
    task automatic rd(input logic [7:0] ad, input logic [31:0] exp);
        apb(1'b0, ad, 32'h0);
        check(rdv, exp);
    endtask
    task automatic read_defaults;
        rd(`OFS_CTRL, 32'h0);
        rd(`OFS_RESOLUTION, 32'h1);
        rd(`OFS_A_TARGET, 32'h0);
        rd(`OFS_Z_TARGET, 32'h1);
    endtask
    task automatic burst(input int n, input logic r, input logic [31:0] exp);
        logic [31:0] base;
        base = trig_n;
        repeat (n)
        begin
            @(posedge mclk);
            req <= 1'b1;
            rv <= r;
            @(posedge mclk);
            req <= 1'b0;
            repeat (6) @(posedge mclk);
        end
        check(trig_n - base, exp);
    endtask
    always @(posedge mclk)
    begin
        last_t <= trig_pulse;
        if (trig_pulse === 1'b1)
        begin
            trig_n <= trig_n + 32'h1;
            check({31'h0, last_t}, 32'h0);
        end
    end
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        repeat (6000) @(posedge mclk);
        bad_count++;
        summarize();
    end
    initial
    begin
        {rst, psel, penable, pwrite, paddr, pwdata, req, rv, win, stp} = {4'h8, 8'h0, 32'h0, 4'h0};
        {trig_n, last_t, bad_count, n_checks} = '0;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        read_defaults();
        rd(8'h14, 32'h0);
        check({31'h0, err}, 32'h1);
        wr(`OFS_RESOLUTION, 32'h0);
        rd(`OFS_RESOLUTION, 32'h1);
        wr(`OFS_Z_TARGET, 32'h0);
        rd(`OFS_Z_TARGET, 32'h1);
        $display("test reset values done");
        win <= 1'b1;
        burst(4, 1'b0, 32'h0);
        wr(`OFS_RESOLUTION, 32'h4);
        wr(`OFS_A_TARGET, 32'h3);
        wr(`OFS_CTRL, C_EN);
        apb(1'b0, `OFS_STATUS, 32'h0);
        s0 = rdv;
        burst(8, 1'b0, 32'h2);
        rd(`OFS_STATUS, {s0[31:24] + 8'h2, 24'h2});
        win <= 1'b0;
        burst(4, 1'b0, 32'h0);
        $display("test window start done");
        wr(`OFS_CTRL, C_EN | C_STEP);
        win <= 1'b1;
        burst(4, 1'b0, 32'h0);
        stp <= 1'b1;
        @(posedge mclk);
        stp <= 1'b0;
        apb(1'b0, `OFS_STATUS, 32'h0);
        check(rdv & 32'h00020000, 32'h00020000);
        burst(4, 1'b0, 32'h1);
        $display("test step start done");
        win <= 1'b0;
        wr(`OFS_CTRL, C_EN | C_SRCZ);
        wr(`OFS_Z_TARGET, 32'h2);
        win <= 1'b1;
        burst(16, 1'b0, 32'h2);
        win <= 1'b0;
        wr(`OFS_CTRL, C_EN | C_PROT | C_ROTZ);
        wr(`OFS_A_TARGET, 32'h2);
        win <= 1'b1;
        burst(8, 1'b0, 32'h2);
        $display("test sources done");
        win <= 1'b0;
        wr(`OFS_CTRL, C_EN | C_BACK);
        wr(`OFS_A_TARGET, 32'h1);
        win <= 1'b1;
        burst(4, 1'b1, 32'h0);
        wr(`OFS_CTRL, C_EN | C_BACK | C_REV);
        burst(4, 1'b1, 32'h4);
        apb(1'b0, `OFS_STATUS, 32'h0);
        check(rdv & 32'h00010000, 32'h00010000);
        wr(`OFS_CTRL, C_EN);
        burst(2, 1'b1, 32'h2);
        $display("test reverse done");
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        read_defaults();
        $display("test mid-run reset done");
        summarize();
    end
endmodule
`default_nettype wire
